// [design/dsc_ctrl.sv]
// dual-slope conversion timing and control with apb registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module dsc_ctrl #(
  parameter int INTEG_TICKS = dsc_pkg::INTEG_TICKS,
  parameter int CNT_W = dsc_pkg::CNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire logic zero_detect,
  input wire logic input_positive,
  output dsc_pkg::dsc_analog_type analog,
  // display
  output logic [CNT_W-1:0] display_count,
  output logic display_negative
);
  typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_READ} dsc_state_type;
  dsc_state_type state;
  logic tick;
  logic [31:0] ctrl;
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] count;
  logic done;
  logic overrange;
  logic pol_neg;
  logic [2:0] func;
  logic [2:0] range;
  logic enable;
  logic start;
  logic integ_end;
  logic read_end;

  assign func = ctrl[dsc_pkg::CTRL_FUNC_LSB +: 3];
  assign range = ctrl[dsc_pkg::CTRL_RANGE_LSB +: 3];
  assign enable = ctrl[dsc_pkg::CTRL_EN_BIT];

  // ac functions pass through the rms converter, always positive
  function automatic logic is_ac(input logic [2:0] f);
    return f == dsc_pkg::FUNC_VAC || f == dsc_pkg::FUNC_IAC;
  endfunction : is_ac

  // address decode for the error flag, kept apart from the read mux
  function automatic logic is_mapped(input logic [7:0] a);
    return a == dsc_pkg::ADDR_CTRL || a == dsc_pkg::ADDR_STATUS ||
      a == dsc_pkg::ADDR_RESULT;
  endfunction : is_mapped

  dsc_tick_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb: zero-wait, pslverr on unmapped address
  logic acc;
  assign acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dsc_pkg::CTRL_RESET;
    end else if (acc && pwrite && paddr == dsc_pkg::ADDR_CTRL) begin
      ctrl <= {23'h000000, pwdata[8:0]};
    end
  end
  // registered read data, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(paddr);
      unique case (paddr)
        dsc_pkg::ADDR_CTRL: prdata <= ctrl;
        dsc_pkg::ADDR_STATUS:
          prdata <= {27'h0, overrange, pol_neg, done, state};
        dsc_pkg::ADDR_RESULT:
          prdata <= {{(32-CNT_W){1'b0}}, display_count};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain and division per function and range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog.gain_x10 <= 1'b0;
      analog.divide_by_ten <= 1'b0;
    end else if (func == dsc_pkg::FUNC_OHM) begin
      // ranges 0..5: 200, 2k, 20k, 200k, 2000k, 20M
      unique case (range)
        3'h0, 3'h1, 3'h3: begin
          analog.gain_x10 <= 1'b1;
          analog.divide_by_ten <= 1'b0;
        end
        3'h5: begin
          analog.gain_x10 <= 1'b0;
          analog.divide_by_ten <= 1'b1;
        end
        default: begin
          analog.gain_x10 <= 1'b0;
          analog.divide_by_ten <= 1'b0;
        end
      endcase
    end else begin
      // lowest range needs x10; divider/shunt scales the rest to 2 V
      analog.gain_x10 <= (range == 3'h0);
      analog.divide_by_ten <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer events, each true only in the clock that carries a tick
  assign start = tick && state == ST_IDLE && enable;
  assign integ_end = tick && state == ST_INTEG &&
    timer == CNT_W'(INTEG_TICKS - 1);
  // saturating count guards a missing zero-detect
  assign read_end = tick && state == ST_READ && (zero_detect || &count);

  // conversion state, advances only on the oscillator tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (tick) begin
      unique case (state)
        ST_IDLE: begin
          if (enable) begin
            state <= ST_INTEG;
          end
        end
        ST_INTEG: begin
          if (integ_end) begin
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (read_end) begin
            state <= enable ? ST_INTEG : ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // integrate timer, restarted whenever a new period opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= '0;
    end else if (start || read_end) begin
      timer <= '0;
    end else if (tick && state == ST_INTEG && !integ_end) begin
      timer <= timer + 1'b1;
    end
  end

  // read counter: zeroed as the reference goes on, one step per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (integ_end) begin
      count <= '0;
    end else if (tick && state == ST_READ && !read_end) begin
      count <= count + 1'b1;
    end
  end

  // input switch: on for the whole integrate period and nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog.connect_input <= 1'b0;
    end else if (start) begin
      analog.connect_input <= 1'b1;
    end else if (integ_end) begin
      analog.connect_input <= 1'b0;
    end else if (read_end) begin
      analog.connect_input <= enable;
    end
  end

  // reference switches; polarity is taken on the tick that ends integrate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_neg <= 1'b0;
      analog.apply_negative_reference <= 1'b0;
      analog.apply_positive_reference <= 1'b0;
    end else if (integ_end) begin
      // positive input needs negative reference
      pol_neg <= !is_ac(func) && !input_positive;
      analog.apply_negative_reference <=
        is_ac(func) || input_positive;
      analog.apply_positive_reference <=
        !is_ac(func) && !input_positive;
    end else if (read_end) begin
      analog.apply_negative_reference <= 1'b0;
      analog.apply_positive_reference <= 1'b0;
    end
  end

  // result latch; the display holds until the next zero-detect or saturated count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      overrange <= 1'b0;
      display_count <= '0;
      display_negative <= 1'b0;
    end else if (tick) begin
      done <= read_end;
      if (read_end) begin
        display_count <= count;
        display_negative <= pol_neg;
        overrange <= &count;
      end
    end
  end
endmodule : dsc_ctrl

// [design/dsc_pkg.sv]
// package: constants, register map and types for the dual-slope controller
package dsc_pkg;
  // clocking
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int INTEG_MS = 100;
  localparam int INTEG_TICKS = INTEG_MS * (OSC_HZ / 1000);
  localparam int CNT_W = 20;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  // control fields
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_FUNC_LSB = 4;
  localparam int CTRL_EN_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  // measurement functions
  typedef enum logic [2:0] {
    FUNC_VDC = 3'h0,
    FUNC_VAC = 3'h1,
    FUNC_IDC = 3'h2,
    FUNC_IAC = 3'h3,
    FUNC_OHM = 3'h4
  } dsc_func_type;
  // analog switch commands
  typedef struct packed {
    logic connect_input;
    logic apply_negative_reference;
    logic apply_positive_reference;
    logic gain_x10;
    logic divide_by_ten;
  } dsc_analog_type;
endpackage : dsc_pkg

// [design/dsc_tick_div.sv]
// divider producing the 1 MHz oscillator enable pulse
`timescale 1ns/1ps
module dsc_tick_div #(
  parameter int DIV = dsc_pkg::OSC_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one-cycle enable
  output logic tick
);
  logic [7:0] cnt;
  // free-running count, pulse on wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(DIV - 1)) begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : dsc_tick_div

// [tb/dsc_analog_model.sv]
// integrator stand-in: discharges for dis ticks once a reference is on
`timescale 1ns/1ps
module dsc_analog_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // switch commands and scenario knobs
  input dsc_pkg::dsc_analog_type analog,
  input wire logic pol,
  input wire logic [7:0] dis,
  // comparator outputs
  output logic zero_detect,
  output logic input_positive
);
  int c;
  wire ref_on = analog.apply_negative_reference |
    analog.apply_positive_reference;
  // clocks spent discharging, cleared once the reference drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c <= 0;
    else c <= ref_on ? c + 1 : 0;
  end
  // zero is crossed mid tick so the sampling tick never races it
  assign zero_detect = ref_on && c >= 40 * dis - 20;
  assign input_positive = pol;
endmodule : dsc_analog_model

// [tb/dsc_ctrl_monitor.sv]
// port checker for the conversion sequencer and its apb slave
`timescale 1ns/1ps
module dsc_ctrl_monitor #(
  parameter int INTEG_TICKS = dsc_pkg::INTEG_TICKS,
  parameter int CNT_W = dsc_pkg::CNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // analog side and display
  input wire logic input_positive,
  input dsc_pkg::dsc_analog_type analog,
  input wire logic [CNT_W-1:0] display_count
);
  int n;
  wire ref_on = analog.apply_negative_reference |
    analog.apply_positive_reference;
  // clocks spent integrating in the current period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) n <= 0;
    else n <= analog.connect_input ? n + 1 : 0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_input_ref_excl: assert property (
    !(analog.connect_input && ref_on))
    else $error("input and reference both on");
  a_ref_pair_excl: assert property (
    !(analog.apply_negative_reference && analog.apply_positive_reference))
    else $error("both references on");
  a_integ_exact: assert property ($fell(analog.connect_input) |->
    n == INTEG_TICKS * dsc_pkg::OSC_DIV) else $error("integrate length");
  a_count_start: assert property ($rose(ref_on) |->
    $fell(analog.connect_input)) else $error("reference not at input drop");
  a_next_integ: assert property (
    $fell(ref_on) |-> analog.connect_input) else $error("no new integrate");
  a_result_hold: assert property (
    $changed(display_count) |-> $fell(ref_on))
    else $error("display moved outside result");
  a_ref_polarity: assert property (
    $rose(analog.apply_positive_reference) |-> !$past(input_positive))
    else $error("wrong reference sign");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property ($rose(analog.apply_positive_reference));
  cover property ($rose(analog.apply_negative_reference));
  cover property (pslverr);
endmodule : dsc_ctrl_monitor
bind dsc_ctrl dsc_ctrl_monitor #(.INTEG_TICKS(INTEG_TICKS), .CNT_W(CNT_W))
  i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .input_positive(input_positive),
  .analog(analog), .display_count(display_count));

// [tb/test_dual_slope_timing_control.sv]
// self-checking bench for the dual-slope controller
`timescale 1ns/1ps
module test_dual_slope_timing_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pol = 0;
  logic [7:0] paddr = 8'h00, dis = 8'h01;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, zero_detect, input_positive, display_negative, e;
  logic [19:0] display_count;
  dsc_pkg::dsc_analog_type analog;
  int n_mismatch = 0, checks = 0, seed = 32'h8385ecb9, f, r, k;
  always #12.5 pclk = ~pclk;
  dsc_ctrl #(.INTEG_TICKS(20)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_detect(zero_detect), .input_positive(input_positive),
    .analog(analog), .display_count(display_count),
    .display_negative(display_negative));
  dsc_analog_model i_ana (.pclk(pclk), .presetn(presetn), .analog(analog),
    .pol(pol), .dis(dis), .zero_detect(zero_detect),
    .input_positive(input_positive));
  //////////////////////////////////////////////////////////////////////
  // helpers; the read count lags the zero crossing by up to one tick
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle clock so a following call never reassigns psel at once
    @(posedge pclk);
  endtask : apb
  task automatic wait_ci(input logic v);
    for (int i = 0; i < 4000 && analog.connect_input !== v; i++)
      @(posedge pclk);
    if (analog.connect_input !== v) n_mismatch++;
  endtask : wait_ci
  function automatic logic x10(int fn, int rg);
    return fn == 4 ? (rg < 2 || rg == 3) : rg == 0;
  endfunction : x10
  task tally_and_finish;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////
  // hang guard, far beyond the expected run
  initial begin
    #(25 * 40000);
    n_mismatch++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h00, 0);
    chk(q, dsc_pkg::CTRL_RESET);
    apb(1, 8'h0C, 32'hFF);
    chk(32'(e), 1);
    apb(0, 8'h0C, 0);
    chk(q, 0);
    for (f = 0; f < 5; f++) for (r = 0; r < 6; r++) if (f == 4 || r < 5) begin
      apb(1, 8'h00, 32'h100 | f << 4 | r);
      repeat (2) @(posedge pclk);
      chk(32'(analog.gain_x10), 32'(x10(f, r)));
      chk(32'(analog.divide_by_ten), 32'(f == 4 && r == 5));
    end
    // conversions: shortest discharge first, then random ones; start at a
    // fresh integrate so the new function lands well before its end
    wait_ci(0);
    wait_ci(1);
    for (k = 0; k < 6; k++) begin
      f = $random(seed) & 3;
      pol <= 1'($random(seed));
      dis <= k == 0 ? 8'h01 : 8'h02 + 8'($random(seed) & 31);
      apb(1, 8'h00, 32'h100 | f << 4);
      wait_ci(0);
      chk(32'(analog.apply_negative_reference), 32'(f[0] | pol));
      chk(32'(analog.apply_positive_reference), 32'(!f[0] && !pol));
      chk(32'(analog.connect_input), 0);
      wait_ci(1);
      chk(32'(display_count), 32'(dis) - 1);
      chk(32'(display_negative), 32'(!f[0] && !pol));
      apb(0, 8'h08, 0);
      chk(q, 32'(dis) - 1);
    end
    tally_and_finish;
  end
endmodule : test_dual_slope_timing_control
